// File: sip_defs.vh
`ifndef SIP_DEFS_VH
`define SIP_DEFS_VH

// ************************************************************
// Register map (byte addresses, one 16-bit register each)
// ************************************************************
`define SIP_ADDR_W              8
`define SIP_DATA_W              16
`define SIP_OFF_IRQ_MASK        8'h90
`define SIP_OFF_IRQ_STATUS      8'h92
`define SIP_OFF_GLOBAL_CTRL     8'hC6
`define SIP_OFF_WAKE_CTRL       8'hD4
`define SIP_OFF_PIN_STATUS      8'hE0

// ************************************************************
// Field positions
// ************************************************************
`define SIP_GC_LED_MODE_BIT     9
`define SIP_WK_ENABLE_LSB       0
`define SIP_WK_POLARITY_BIT     4
`define SIP_WK_STATUS_LSB       8
`define SIP_WAKE_SRC_N          4
`define SIP_IRQ_LINK_BIT        0
`define SIP_IRQ_SPEED_BIT       1
`define SIP_IRQ_WAKE_BIT        2
`define SIP_IRQ_STRAP_BIT       3
`define SIP_IRQ_EXT_LSB         4
`define SIP_IRQ_EXT_N           4
`define SIP_PS_STRAP_BIT        0
`define SIP_PS_STRAP_VALID_BIT  1
`define SIP_PS_LINK_BIT         2
`define SIP_PS_SPEED_BIT        3
`define SIP_PS_WAKE_BIT         4
`define SIP_PS_IRQ_BIT          5

// ************************************************************
// Reset values
// ************************************************************
`define SIP_RST_LED_MODE        1'b0
`define SIP_RST_WAKE_POLARITY   1'b0
`define SIP_RST_WAKE_ENABLE     4'h0
`define SIP_RST_IRQ_MASK        16'h0000
`define SIP_RST_STRAP           1'b0

// ************************************************************
// Timing
// ************************************************************
`define SIP_CLK_MHZ             125
`define SIP_BLINK_HALF_US       50000
`define SIP_BLINK_HALF_CYC      (`SIP_BLINK_HALF_US * `SIP_CLK_MHZ)
`define SIP_BLINK_HALVES        4
`define SIP_STRAP_SETTLE_CYC    2

`endif

// File: sip_sync2.v
`default_nettype none

// ************************************************************
// Two-stage synchroniser for asynchronous pin levels
// ************************************************************
module sip_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stageOne;
   reg [WIDTH-1:0] stageTwo;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stageOne <= {WIDTH{1'b0}};
         stageTwo <= {WIDTH{1'b0}};
      end else begin
         stageOne <= asyncIn;
         stageTwo <= stageOne;
      end
   end

   assign syncOut = stageTwo;

endmodule // sip_sync2

`default_nettype wire

// File: sip_blinker.v
`default_nettype none

// ************************************************************
// Activity blink generator
// ************************************************************
// Each activity pulse (re)arms a run of HALVES half periods; the phase
// toggles at every half period, so the LED blinks while traffic flows.
module sip_blinker #(
   parameter CNT_W       = 24,
   parameter HALF_CYCLES = 6250000,
   parameter HALVES      = 4
) (
   input  wire clk_sys,
   input  wire rst,
   input  wire activity,
   output reg  busy,
   output reg  phase
);

   localparam integer     HALF_LAST_I = HALF_CYCLES - 1;
   localparam integer     HALF_RUNS_I = HALVES;
   localparam [CNT_W-1:0] HALF_LAST   = HALF_LAST_I[CNT_W-1:0];
   localparam [7:0]       HALF_RUNS   = HALF_RUNS_I[7:0];

   reg [CNT_W-1:0] halfCount;
   reg [7:0]       halvesLeft;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         halfCount  <= {CNT_W{1'b0}};
         halvesLeft <= 8'h00;
         busy       <= 1'b0;
         phase      <= 1'b0;
      end else if (activity) begin
         // Retriggering keeps the phase so a steady stream blinks evenly.
         halvesLeft <= HALF_RUNS;
         busy       <= 1'b1;
         if (!busy) begin
            halfCount <= {CNT_W{1'b0}};
            phase     <= 1'b0;
         end
      end else if (busy) begin
         if (halfCount == HALF_LAST) begin
            halfCount <= {CNT_W{1'b0}};
            phase     <= ~phase;
            if (halvesLeft == 8'h01) begin
               busy       <= 1'b0;
               halvesLeft <= 8'h00;
            end else begin
               halvesLeft <= halvesLeft - 8'h01;
            end
         end else begin
            halfCount <= halfCount + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // sip_blinker

`default_nettype wire

// File: sip_status_pins.v
// Operation
// - LED outputs are active low.
// - Global bit selects LED mapping, default zero.
// - Link steady, activity blinks, speed lit 100.
// - Wake output asserts on enabled wake event.
// - Wake polarity programmable, default active low.
// - Interrupt output low while unmasked status bit set.
// - EEPROM data pin pull sampled as strap.
`include "sip_defs.vh"
`default_nettype none

module sip_status_pins #(
   parameter BLINK_CYCLES = `SIP_BLINK_HALF_CYC,
   parameter BLINK_CNT_W  = 24,
   parameter WAKE_N       = `SIP_WAKE_SRC_N,
   parameter EXT_N        = `SIP_IRQ_EXT_N
) (
   input  wire                     clk_sys,
   input  wire                     rst,
   // Register port.
   input  wire [`SIP_ADDR_W-1:0]   regAddr,
   input  wire [`SIP_DATA_W-1:0]   regWrData,
   input  wire                     regWrite,
   input  wire                     regRead,
   output reg  [`SIP_DATA_W-1:0]   regRdData,
   // Status from the PHY and MAC, same clock domain.
   input  wire                     linkUp,
   input  wire                     speed100,
   input  wire                     activity,
   input  wire [WAKE_N-1:0]        wakeDetect,
   input  wire [EXT_N-1:0]         extIrq,
   // EEPROM loader drive request.
   input  wire                     loaderDataOut,
   input  wire                     loaderDataOe,
   // Pins.
   output reg                      indicator_a_out_n,
   output reg                      indicator_b_out_n,
   output reg                      wake_event_out,
   output reg                      host_irq_n,
   input  wire                     eeprom_data_io_in,
   output reg                      eeprom_data_io_out,
   output reg                      eeprom_data_io_oe,
   output wire                     eepromPresent,
   output wire                     strapValid
);

   // ************************************************************
   // Local constants
   // ************************************************************
   localparam [2:0] ST_SETTLE = 3'b001;
   localparam [2:0] ST_SAMPLE = 3'b010;
   localparam [2:0] ST_HELD   = 3'b100;
   localparam integer SETTLE_LAST_I = `SIP_STRAP_SETTLE_CYC - 1;
   localparam [1:0]   SETTLE_LAST   = SETTLE_LAST_I[1:0];

   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   wire eepromPinSync;

   sip_sync2 #(
      .WIDTH   (1)
   ) u_eepromSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn (eeprom_data_io_in),
      .syncOut (eepromPinSync)
   );

   // ************************************************************
   // Strap capture
   // ************************************************************
   // The pin is left undriven until the strap is held, so only the
   // external pull sets its level while the sample is taken.
   reg [2:0] strapState;
   reg [2:0] next_strapState;
   reg [1:0] settleCount;
   reg       strapLevel;
   reg       strapDone;
   wire      strapEvent;

   always @* begin
      next_strapState = strapState;
      case (strapState)
         ST_SETTLE: begin
            if (settleCount == SETTLE_LAST)
               next_strapState = ST_SAMPLE;
         end
         ST_SAMPLE: next_strapState = ST_HELD;
         ST_HELD:   next_strapState = ST_HELD;
         default:   next_strapState = ST_SETTLE;
      endcase
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         strapState  <= ST_SETTLE;
         settleCount <= 2'b00;
         strapLevel  <= `SIP_RST_STRAP;
         strapDone   <= 1'b0;
      end else begin
         strapState <= next_strapState;
         if (strapState == ST_SETTLE)
            settleCount <= settleCount + 2'b01;
         if (strapState == ST_SAMPLE) begin
            strapLevel <= eepromPinSync;
            strapDone  <= 1'b1;
         end
      end
   end

   assign strapEvent    = (strapState == ST_SAMPLE);
   assign eepromPresent = strapLevel;
   assign strapValid    = strapDone;

   // The loader may drive the data pin only once the strap is held.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         eeprom_data_io_out <= 1'b0;
         eeprom_data_io_oe  <= 1'b0;
      end else begin
         eeprom_data_io_out <= loaderDataOut & strapDone;
         eeprom_data_io_oe  <= loaderDataOe & strapDone & strapLevel;
      end
   end

   // ************************************************************
   // Register decode
   // ************************************************************
   wire hitMask   = (regAddr == `SIP_OFF_IRQ_MASK);
   wire hitStatus = (regAddr == `SIP_OFF_IRQ_STATUS);
   wire hitGlobal = (regAddr == `SIP_OFF_GLOBAL_CTRL);
   wire hitWake   = (regAddr == `SIP_OFF_WAKE_CTRL);
   wire hitPins   = (regAddr == `SIP_OFF_PIN_STATUS);

   reg                     ledMode;
   reg                     wakePolarity;
   reg [WAKE_N-1:0]        wakeEnable;
   reg [WAKE_N-1:0]        wakeStatus;
   reg [`SIP_DATA_W-1:0]   irqMask;
   reg [`SIP_DATA_W-1:0]   irqStatus;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ledMode      <= `SIP_RST_LED_MODE;
         wakePolarity <= `SIP_RST_WAKE_POLARITY;
         wakeEnable   <= `SIP_RST_WAKE_ENABLE;
         irqMask      <= `SIP_RST_IRQ_MASK;
      end else if (regWrite) begin
         if (hitGlobal)
            ledMode <= regWrData[`SIP_GC_LED_MODE_BIT];
         if (hitWake) begin
            wakePolarity <= regWrData[`SIP_WK_POLARITY_BIT];
            wakeEnable   <= regWrData[`SIP_WK_ENABLE_LSB +: WAKE_N];
         end
         if (hitMask)
            irqMask <= regWrData;
      end
   end

   // ************************************************************
   // Wake event logic
   // ************************************************************
   // Detected, enabled events are held until software writes a one to
   // the matching status bit; a detection in that cycle wins.
   wire [WAKE_N-1:0] wakeClear = (regWrite && hitWake) ?
                                 regWrData[`SIP_WK_STATUS_LSB +: WAKE_N] :
                                 {WAKE_N{1'b0}};
   wire              wakeActive = |wakeStatus;

   genvar w;
   generate
      for (w = 0; w < WAKE_N; w = w + 1) begin : g_wake
         always @(posedge clk_sys or posedge rst) begin
            if (rst)
               wakeStatus[w] <= 1'b0;
            else if (wakeDetect[w] && wakeEnable[w])
               wakeStatus[w] <= 1'b1;
            else if (wakeClear[w])
               wakeStatus[w] <= 1'b0;
         end
      end
   endgenerate

   // Polarity zero means active low; the idle level follows the setting.
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         wake_event_out <= 1'b1;
      else
         wake_event_out <= wakePolarity ? wakeActive : ~wakeActive;
   end

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   reg                   linkLast;
   reg                   speedLast;
   reg                   wakeLast;
   wire [`SIP_DATA_W-1:0] irqSet;
   wire [`SIP_DATA_W-1:0] irqClear;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         linkLast  <= 1'b0;
         speedLast <= 1'b0;
         wakeLast  <= 1'b0;
      end else begin
         linkLast  <= linkUp;
         speedLast <= speed100;
         wakeLast  <= wakeActive;
      end
   end

   assign irqSet[`SIP_IRQ_LINK_BIT]  = linkUp ^ linkLast;
   assign irqSet[`SIP_IRQ_SPEED_BIT] = speed100 ^ speedLast;
   assign irqSet[`SIP_IRQ_WAKE_BIT]  = wakeActive & ~wakeLast;
   assign irqSet[`SIP_IRQ_STRAP_BIT] = strapEvent;
   assign irqSet[`SIP_IRQ_EXT_LSB +: EXT_N] = extIrq;
   assign irqSet[`SIP_DATA_W-1:`SIP_IRQ_EXT_LSB+EXT_N] =
          {(`SIP_DATA_W-`SIP_IRQ_EXT_LSB-EXT_N){1'b0}};
   assign irqClear = (regWrite && hitStatus) ? regWrData : {`SIP_DATA_W{1'b0}};

   genvar b;
   generate
      for (b = 0; b < `SIP_DATA_W; b = b + 1) begin : g_irq
         always @(posedge clk_sys or posedge rst) begin
            if (rst)
               irqStatus[b] <= 1'b0;
            else if (irqSet[b])
               irqStatus[b] <= 1'b1;
            else if (irqClear[b])
               irqStatus[b] <= 1'b0;
         end
      end
   endgenerate

   wire irqPending = |(irqStatus & irqMask);

   // Pulled low while any unmasked bit is set, released otherwise.
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         host_irq_n <= 1'b1;
      else
         host_irq_n <= ~irqPending;
   end

   // ************************************************************
   // LED indication
   // ************************************************************
   wire blinkBusy;
   wire blinkPhase;

   sip_blinker #(
      .CNT_W       (BLINK_CNT_W),
      .HALF_CYCLES (BLINK_CYCLES),
      .HALVES      (`SIP_BLINK_HALVES)
   ) u_blinker (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .activity (activity),
      .busy     (blinkBusy),
      .phase    (blinkPhase)
   );

   // Lit levels before the active-low inversion at the pins.
   wire litLink    = linkUp;
   wire litAct     = blinkBusy & blinkPhase;
   wire litLinkAct = linkUp & (~blinkBusy | blinkPhase);
   wire litSpeed   = linkUp & speed100;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         indicator_a_out_n <= 1'b1;
         indicator_b_out_n <= 1'b1;
      end else if (ledMode) begin
         indicator_a_out_n <= ~litLink;
         indicator_b_out_n <= ~litAct;
      end else begin
         indicator_a_out_n <= ~litLinkAct;
         indicator_b_out_n <= ~litSpeed;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   // Read data stand for exactly one cycle; unmapped addresses read zero.
   reg [`SIP_DATA_W-1:0] readMux;

   always @* begin
      readMux = {`SIP_DATA_W{1'b0}};
      if (hitMask)
         readMux = irqMask;
      if (hitStatus)
         readMux = irqStatus;
      if (hitGlobal)
         readMux[`SIP_GC_LED_MODE_BIT] = ledMode;
      if (hitWake) begin
         readMux[`SIP_WK_ENABLE_LSB +: WAKE_N] = wakeEnable;
         readMux[`SIP_WK_POLARITY_BIT]         = wakePolarity;
         readMux[`SIP_WK_STATUS_LSB +: WAKE_N] = wakeStatus;
      end
      if (hitPins) begin
         readMux[`SIP_PS_STRAP_BIT]       = strapLevel;
         readMux[`SIP_PS_STRAP_VALID_BIT] = strapDone;
         readMux[`SIP_PS_LINK_BIT]        = linkUp;
         readMux[`SIP_PS_SPEED_BIT]       = speed100;
         readMux[`SIP_PS_WAKE_BIT]        = wakeActive;
         readMux[`SIP_PS_IRQ_BIT]         = irqPending;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         regRdData <= {`SIP_DATA_W{1'b0}};
      else if (regRead)
         regRdData <= readMux;
      else
         regRdData <= {`SIP_DATA_W{1'b0}};
   end

endmodule // sip_status_pins

`default_nettype wire

// File: sip_status_pins_assertions.sv
`include "sip_defs.vh"
`default_nettype none
// ************************************************************
// Port checker
// ************************************************************
module sip_chk (
   input wire logic                       clk_sys,
   input wire logic                       rst,
   input wire logic                       regWrite,
   input wire logic                       regRead,
   input wire logic [`SIP_DATA_W-1:0]     regRdData,
   input wire logic                       linkUp,
   input wire logic                       speed100,
   input wire logic [`SIP_WAKE_SRC_N-1:0] wakeDetect,
   input wire logic [`SIP_IRQ_EXT_N-1:0]  extIrq,
   input wire logic                       loaderDataOe,
   input wire logic                       indicator_a_out_n,
   input wire logic                       wake_event_out,
   input wire logic                       host_irq_n,
   input wire logic                       eeprom_data_io_in,
   input wire logic                       eeprom_data_io_oe,
   input wire logic                       eepromPresent,
   input wire logic                       strapValid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] sinceRst;
   logic       prevLink;
   logic       prevSpeed;
   wire logic  anyEvent;
   // Anything but the strap event that may set a status bit or move the wake pin two edges later.
   assign anyEvent = regWrite | (|extIrq) | (|wakeDetect) | (linkUp ^ prevLink)
                     | (speed100 ^ prevSpeed);
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sinceRst <= 3'h0;
         prevLink <= 1'h0;
         prevSpeed <= 1'h0;
      end else begin
         sinceRst <= (sinceRst == 3'h7) ? sinceRst : sinceRst + 3'h1;
         prevLink <= linkUp;
         prevSpeed <= speed100;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence sStrapLatched;
      $rose(strapValid);
   endsequence
   AST_LED_DARK_NO_LINK: assert property (!$past(linkUp) |-> indicator_a_out_n)
      else $error("LED A lit without link");
   AST_STRAP_EARLY: assert property (sinceRst < 3'h3 |-> !strapValid)
      else $error("strap valid too early");
   AST_STRAP_LATE: assert property (sinceRst >= 3'h3 |-> strapValid)
      else $error("strap not latched in time");
   AST_STRAP_VALUE: assert property (sStrapLatched |-> eepromPresent == eeprom_data_io_in)
      else $error("strap value differs from pin");
   AST_STRAP_HOLD: assert property (strapValid && $past(strapValid) |->
      $stable(eepromPresent))
      else $error("strap changed after latch");
   AST_IRQ_RELEASE: assert property ($rose(host_irq_n) |-> $past(regWrite, 2))
      else $error("irq released without a write");
   // A wake event reaches its status bit one edge later than the other causes.
   AST_IRQ_ASSERT: assert property ($fell(host_irq_n) |->
      $past(anyEvent, 2) || $past(anyEvent, 3))
      else $error("irq asserted without a cause");
   AST_WAKE_CAUSE: assert property ($changed(wake_event_out) |-> $past(anyEvent, 2))
      else $error("wake pin moved without a cause");
   AST_EE_DRIVE: assert property (eeprom_data_io_oe |->
      strapValid && eepromPresent && $past(loaderDataOe))
      else $error("eeprom pin driven while not allowed");
   AST_READ_STANDS: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("read data outside its cycle");
endmodule // sip_chk
bind sip_status_pins sip_chk sip_chk_i (
   .clk_sys(clk_sys), .rst(rst), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .linkUp(linkUp), .speed100(speed100), .wakeDetect(wakeDetect),
   .extIrq(extIrq), .loaderDataOe(loaderDataOe), .indicator_a_out_n(indicator_a_out_n),
   .wake_event_out(wake_event_out), .host_irq_n(host_irq_n),
   .eeprom_data_io_in(eeprom_data_io_in), .eeprom_data_io_oe(eeprom_data_io_oe),
   .eepromPresent(eepromPresent), .strapValid(strapValid));
`default_nettype wire

// File: sip_far_side.sv
`default_nettype none
// ************************************************************
// Board around the pins: strap resistor, LEDs, host input
// ************************************************************
module sip_far_side (
   input  wire logic pullHigh,
   input  wire logic eeOut,
   input  wire logic eeOe,
   input  wire logic ledANeg,
   input  wire logic ledBNeg,
   input  wire logic irqNeg,
   output logic      eePin,
   output logic      ledALit,
   output logic      ledBLit,
   output logic      irqSeen
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin rests at the strap resistor, never at the last driven value.
   assign eePin = eeOe ? eeOut : pullHigh;
   assign ledALit = !ledANeg;
   assign ledBLit = !ledBNeg;
   assign irqSeen = !irqNeg;
endmodule // sip_far_side
`default_nettype wire

// File: sip_tb.sv
`include "sip_defs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BLINK = 4;
   logic                       clk_sys, rst, regWrite, regRead;
   logic [`SIP_ADDR_W-1:0]     regAddr;
   logic [`SIP_DATA_W-1:0]     regWrData;
   wire logic [`SIP_DATA_W-1:0] regRdData;
   logic                       linkUp, speed100, activity, loaderDataOut, loaderDataOe, pullHigh;
   logic [3:0]                 wakeDetect, extIrq;
   wire logic                  ledANeg, ledBNeg, wakePin, irqNeg, eeIn, eeOut, eeOe;
   wire logic                  present, valid, ledA, ledB, irqOn;
   int                         err_total, n_compared, lit, dark;
   sip_status_pins #(.BLINK_CYCLES(BLINK)) sip_status_pins_i (
      .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .linkUp(linkUp),
      .speed100(speed100), .activity(activity), .wakeDetect(wakeDetect), .extIrq(extIrq),
      .loaderDataOut(loaderDataOut), .loaderDataOe(loaderDataOe),
      .indicator_a_out_n(ledANeg), .indicator_b_out_n(ledBNeg), .wake_event_out(wakePin),
      .host_irq_n(irqNeg), .eeprom_data_io_in(eeIn), .eeprom_data_io_out(eeOut),
      .eeprom_data_io_oe(eeOe), .eepromPresent(present), .strapValid(valid));
   sip_far_side sip_far_side_i (.pullHigh(pullHigh), .eeOut(eeOut), .eeOe(eeOe),
      .ledANeg(ledANeg), .ledBNeg(ledBNeg), .irqNeg(irqNeg), .eePin(eeIn),
      .ledALit(ledA), .ledBLit(ledB), .irqSeen(irqOn));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic mis(input string m);
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic cmp1(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e) mis(m);
   endtask
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e, input string m);
      n_compared++;
      if (g !== e) mis(m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWrite <= 1'h1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrite <= 1'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string m);
      @(posedge clk_sys);
      regRead <= 1'h1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'h0;
      #1;
      cmp16(regRdData, e, m);
   endtask
   task automatic pulseAct;
      @(posedge clk_sys);
      activity <= 1'h1;
      @(posedge clk_sys);
      activity <= 1'h0;
   endtask
   task automatic pulseWake(input logic [3:0] v);
      @(posedge clk_sys);
      wakeDetect <= v;
      @(posedge clk_sys);
      wakeDetect <= 4'h0;
      tick(3);
   endtask
   task automatic watch(input logic selB);
      lit = 0;
      dark = 0;
      repeat (30) begin
         tick(1);
         if ((selB ? ledB : ledA) === 1'h1) lit++;
         else dark++;
      end
   endtask
   task automatic doReset(input logic pull);
      @(posedge clk_sys);
      pullHigh <= pull;
      rst <= 1'h1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
      tick(8);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      doReset(1'h1);
      cmp1(ledANeg, 1'h1, "led a idle");
      cmp1(ledBNeg, 1'h1, "led b idle");
      cmp1(wakePin, 1'h1, "wake idle high");
      cmp1(irqNeg, 1'h1, "irq released");
      cmp1(valid, 1'h1, "strap valid");
      cmp1(present, 1'h1, "eeprom seen");
      rdc(`SIP_OFF_PIN_STATUS, 16'h0003, "pin status");
      rdc(`SIP_OFF_IRQ_STATUS, 16'h0008, "strap event");
      rdc(`SIP_OFF_GLOBAL_CTRL, 16'h0000, "global ctrl reset");
      rdc(`SIP_OFF_WAKE_CTRL, 16'h0000, "wake ctrl reset");
      rdc(8'h40, 16'h0000, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_strap;
      @(posedge clk_sys);
      pullHigh <= 1'h0;
      loaderDataOe <= 1'h1;
      loaderDataOut <= 1'h1;
      tick(6);
      cmp1(present, 1'h1, "strap held");
      cmp1(eeOe, 1'h1, "loader drives");
      cmp1(eeOut, 1'h1, "loader data out");
      doReset(1'h0);
      cmp1(present, 1'h0, "no eeprom");
      cmp1(eeOe, 1'h0, "loader blocked");
      rdc(`SIP_OFF_PIN_STATUS, 16'h0002, "no eeprom status");
      @(posedge clk_sys);
      loaderDataOe <= 1'h0;
      loaderDataOut <= 1'h0;
      doReset(1'h1);
      $display("test strap done");
   endtask
   task automatic t_leds;
      @(posedge clk_sys);
      linkUp <= 1'h1;
      speed100 <= 1'h1;
      tick(3);
      cmp1(ledA, 1'h1, "link lights a");
      cmp1(ledB, 1'h1, "speed lights b");
      @(posedge clk_sys);
      speed100 <= 1'h0;
      tick(3);
      cmp1(ledB, 1'h0, "low speed dark");
      pulseAct();
      watch(1'h0);
      cmp1(dark > 0 && lit > 0, 1'h1, "link act blinks");
      cmp1(ledA, 1'h1, "link act steady after");
      wr(`SIP_OFF_GLOBAL_CTRL, 16'h0200);
      @(posedge clk_sys);
      speed100 <= 1'h1;
      tick(3);
      cmp1(ledB, 1'h0, "act idle dark");
      pulseAct();
      watch(1'h1);
      cmp1(dark > 0 && lit > 0, 1'h1, "act blinks");
      cmp1(ledA, 1'h1, "a shows link");
      @(posedge clk_sys);
      linkUp <= 1'h0;
      tick(3);
      cmp1(ledA, 1'h0, "no link dark");
      wr(`SIP_OFF_GLOBAL_CTRL, 16'h0000);
      $display("test leds done");
   endtask
   task automatic t_wake;
      wr(`SIP_OFF_WAKE_CTRL, 16'h0001);
      pulseWake(4'h2);
      cmp1(wakePin, 1'h1, "disabled source ignored");
      pulseWake(4'h1);
      cmp1(wakePin, 1'h0, "wake asserted low");
      rdc(`SIP_OFF_WAKE_CTRL, 16'h0101, "wake status");
      wr(`SIP_OFF_WAKE_CTRL, 16'h0101);
      tick(3);
      cmp1(wakePin, 1'h1, "wake cleared");
      wr(`SIP_OFF_WAKE_CTRL, 16'h0011);
      tick(3);
      cmp1(wakePin, 1'h0, "high polarity idle");
      pulseWake(4'h1);
      cmp1(wakePin, 1'h1, "wake asserted high");
      wr(`SIP_OFF_WAKE_CTRL, 16'h0100);
      tick(3);
      cmp1(wakePin, 1'h1, "default polarity idle");
      $display("test wake done");
   endtask
   task automatic t_irq;
      wr(`SIP_OFF_IRQ_STATUS, 16'hFFFF);
      rdc(`SIP_OFF_IRQ_MASK, 16'h0000, "mask reset");
      wr(`SIP_OFF_IRQ_MASK, 16'h0010);
      @(posedge clk_sys);
      extIrq <= 4'h3;
      @(posedge clk_sys);
      extIrq <= 4'h0;
      tick(3);
      cmp1(irqOn, 1'h1, "irq pin low");
      rdc(`SIP_OFF_IRQ_STATUS, 16'h0030, "status sticky");
      wr(`SIP_OFF_IRQ_STATUS, 16'h0010);
      tick(3);
      cmp1(irqOn, 1'h0, "masked bit silent");
      wr(`SIP_OFF_IRQ_MASK, 16'h0020);
      tick(3);
      cmp1(irqOn, 1'h1, "unmask drives");
      wr(`SIP_OFF_IRQ_MASK, 16'h0000);
      tick(3);
      cmp1(irqOn, 1'h0, "mask releases");
      $display("test irq done");
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'h1;
      {regWrite, regRead, linkUp, speed100, activity} = 5'h00;
      {loaderDataOut, loaderDataOe, pullHigh} = 3'h1;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      wakeDetect = 4'h0;
      extIrq = 4'h0;
      err_total = 0;
      n_compared = 0;
      t_reset();
      t_strap();
      t_leds();
      t_wake();
      t_irq();
      test_done();
   end
   // The whole run needs well under two thousand cycles.
   initial begin
      #160000;
      mis("watchdog expired");
      test_done();
   end
endmodule // tb
`default_nettype wire
